// >>> core/fbp_pad.sv
// Pad register stage that turns a selected drive into pin signals.
`timescale 1ns/1ps
module fbp_pad (
  input wire logic clk,
  input wire logic rst_n,
  fbp_pin_if.pad sel,
  output logic pin_out,
  output logic pin_oe
);
  // Open drain drives only low; a high level releases the pin.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pin_out <= 1'b0;
      pin_oe <= 1'b0;
    end else begin
      pin_out <= sel.drive_val;
      pin_oe <= sel.drive_en & (~sel.open_drain | ~sel.drive_val);
    end
  end
endmodule // fbp_pad

// >>> core/fbp_pin_if.sv
// Interface carrying one pin's selected drive between mux and pad cell.
`timescale 1ns/1ps
interface fbp_pin_if;
  logic drive_en;
  logic drive_val;
  logic open_drain;
  modport mux (output drive_en, output drive_val, output open_drain);
  modport pad (input drive_en, input drive_val, input open_drain);
endinterface

// >>> core/fbp_pkg.sv
// Package of constants for the four-bit multiplexed I/O port.
// Function
// - Direction register is write-only, reads undefined
// - Direction 1 means output, 0 input
// - Output data bits 3..0, upper read zero
// - Pin state reads data if output, pin if input
// - Pin state read-only, upper bits undefined
// - Open-drain bit selects NMOS drain unless bus outputs
// - Pin 3 feeds converter trigger when selected
// - Pin n feeds interrupt n when select is 0
// - Pin 2 drives bus acknowledge, overriding all
// - Alternate peripherals appear only when selected
// - Pin 2 priority: pulse, byte timer, serial clock
// - I2C clock and data always open-drain
// - Pin 0 drives bus request output, overriding all
// - Single-chip modes disable bus release functions
// - Channel 4 output follows mode and clear settings
// - Channel 3 PWM2 output when clear differs
// - Pin 3 claimed only by trigger, port, interrupt
package fbp_pkg;
  localparam int FBP_NPINS = 4;
  // ---------------------------------------------------------------
  // Register byte addresses.
  // ---------------------------------------------------------------
  localparam logic [3:0] FBP_ADDR_DIR = 4'h0;
  localparam logic [3:0] FBP_ADDR_DATA = 4'h4;
  localparam logic [3:0] FBP_ADDR_PIN = 4'h8;
  localparam logic [3:0] FBP_ADDR_ODR = 4'hC;
  // ---------------------------------------------------------------
  // Reset values and read filler.
  // ---------------------------------------------------------------
  localparam logic [3:0] FBP_DIR_RST = 4'h0;
  localparam logic [3:0] FBP_DATA_RST = 4'h0;
  localparam logic [3:0] FBP_ODR_RST = 4'h0;
  localparam logic [31:0] FBP_UNDEF_READ = 32'h0000_0000;
  localparam logic [1:0] FBP_RESP_OKAY = 2'h0;
  localparam logic [1:0] FBP_RESP_SLVERR = 2'h2;
  // ---------------------------------------------------------------
  // Pulse unit field encodings.
  // ---------------------------------------------------------------
  localparam logic [3:0] FBP_MD_NORMAL = 4'h0;
  localparam logic [3:0] FBP_MD_PWM1 = 4'h2;
  localparam logic [3:0] FBP_MD_PWM2 = 4'h3;
  localparam logic [1:0] FBP_CCLR4_OWN = 2'h2;
  localparam logic [2:0] FBP_CCLR3_C = 3'h5;
  localparam logic [2:0] FBP_CCLR3_A = 3'h1;
  // Operating modes that are single chip when expansion is off.
  localparam logic [2:0] FBP_MODE_3 = 3'h3;
  localparam logic [2:0] FBP_MODE_5 = 3'h5;
  localparam logic [2:0] FBP_MODE_7 = 3'h7;
endpackage

// >>> core/fbp_port.sv
// Four-bit I/O port with AXI4-Lite registers and peripheral pin multiplexing.
//
// The register offsets and the AXI4-Lite register port were chosen for this implementation.
`timescale 1ns/1ps
module fbp_port
  import fbp_pkg::*;
(
  input wire logic MCLK,
  input wire logic RESET_N,
  input wire logic [3:0] S_AXI_AWADDR,
  input wire logic S_AXI_AWVALID,
  output logic S_AXI_AWREADY,
  input wire logic [31:0] S_AXI_WDATA,
  input wire logic [3:0] S_AXI_WSTRB,
  input wire logic S_AXI_WVALID,
  output logic S_AXI_WREADY,
  output logic [1:0] S_AXI_BRESP,
  output logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  input wire logic [3:0] S_AXI_ARADDR,
  input wire logic S_AXI_ARVALID,
  output logic S_AXI_ARREADY,
  output logic [31:0] S_AXI_RDATA,
  output logic [1:0] S_AXI_RRESP,
  output logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY,
  input wire logic [3:0] PIN_IN,
  output logic [3:0] PIN_OUT,
  output logic [3:0] PIN_OE,
  input wire logic [2:0] OPERATING_MODE,
  input wire logic EXTERNAL_EXPANSION,
  input wire logic BUS_RELEASE_ENABLE,
  input wire logic BUS_ACK_PIN_SELECT,
  input wire logic BUS_REQUEST_PIN_SELECT,
  input wire logic BUS_REQUEST_OUT_ENABLE,
  input wire logic BUS_REQUEST_OUT_PIN_SELECT,
  input wire logic BUS_ACK_OUT,
  input wire logic BUS_REQUEST_OUTPUT,
  input wire logic IIC_BUS_ENABLE,
  input wire logic IIC_CLOCK_OUT,
  input wire logic IIC_DATA_OUT,
  input wire logic RX_ENABLE,
  input wire logic TRANSMIT_ENABLE,
  input wire logic SERIAL_TRANSMIT_OUT,
  input wire logic SERIAL_CLOCK_OUT,
  input wire logic SERIAL_SYNC_MODE,
  input wire logic SERIAL_CLOCK_SEL_LOW,
  input wire logic SERIAL_CLOCK_SEL_HIGH,
  input wire logic PATTERN_OUT_ENABLE_FOUR,
  input wire logic PATTERN_OUT_ENABLE_TWO,
  input wire logic PATTERN_OUT_ENABLE_ZERO,
  input wire logic [2:0] PATTERN_OUT,
  input wire logic PATTERN_PIN_SELECT,
  input wire logic PULSE_UNIT_PIN_SELECT,
  input wire logic BYTE_TIMER_PIN_SELECT,
  input wire logic [3:0] BYTE_TIMER_OUTPUT_SELECT,
  input wire logic BYTE_TIMER_OUTPUT_ALT,
  input wire logic [3:0] PULSE_CH4_MODE,
  input wire logic [3:0] PULSE_CH4_IO_SELECT,
  input wire logic [1:0] PULSE_CH4_CLEAR_SELECT,
  input wire logic PULSE_CH4_OUT,
  input wire logic [3:0] PULSE_CH3_MODE,
  input wire logic [3:0] PULSE_CH3_IOA_SELECT,
  input wire logic [3:0] PULSE_CH3_IOC_SELECT,
  input wire logic [2:0] PULSE_CH3_CLEAR_SELECT,
  input wire logic PULSE_CH3A_OUT,
  input wire logic PULSE_CH3C_OUT,
  input wire logic CONV_TRIGGER_SEL_HIGH,
  input wire logic CONV_TRIGGER_SEL_LOW,
  input wire logic CONV_EXTENDED_TRIGGER_SEL,
  input wire logic [3:0] IRQ_PIN_SELECT,
  output logic CONV_EXTERNAL_TRIGGER,
  output logic [3:0] IRQ_ALT_A,
  output logic SERIAL_RECEIVE_IN,
  output logic SERIAL_CLOCK_IN,
  output logic BUS_REQUEST_INPUT,
  output logic IIC_CLOCK_IN,
  output logic IIC_DATA_IN,
  output logic [3:0] PULSE_UNIT_IO_IN
);
  // ---------------------------------------------------------------
  // Register file and bus slave.
  // ---------------------------------------------------------------
  logic [3:0] port_direction_r;
  logic [3:0] port_output_data_r;
  logic [3:0] port_open_drain_r;
  logic [3:0] aw_addr_r;
  logic aw_held_r;
  logic [31:0] w_data_r;
  logic [3:0] w_strb_r;
  logic w_held_r;
  logic do_write;
  logic [3:0] pin_state;
  logic [31:0] rdata_nxt;
  logic [1:0] rresp_nxt;

  assign do_write = aw_held_r & w_held_r & ~S_AXI_BVALID;

  always_ff @(posedge MCLK) begin
    if (!RESET_N) begin
      S_AXI_AWREADY <= 1'b0;
      aw_held_r <= 1'b0;
      aw_addr_r <= 4'h0;
    end else begin
      S_AXI_AWREADY <= ~aw_held_r & ~S_AXI_AWREADY & S_AXI_AWVALID;
      if (S_AXI_AWVALID & S_AXI_AWREADY) begin
        aw_held_r <= 1'b1;
        aw_addr_r <= S_AXI_AWADDR;
      end else if (do_write) begin
        aw_held_r <= 1'b0;
      end
    end
  end

  always_ff @(posedge MCLK) begin
    if (!RESET_N) begin
      S_AXI_WREADY <= 1'b0;
      w_held_r <= 1'b0;
      w_data_r <= 32'h0000_0000;
      w_strb_r <= 4'h0;
    end else begin
      S_AXI_WREADY <= ~w_held_r & ~S_AXI_WREADY & S_AXI_WVALID;
      if (S_AXI_WVALID & S_AXI_WREADY) begin
        w_held_r <= 1'b1;
        w_data_r <= S_AXI_WDATA;
        w_strb_r <= S_AXI_WSTRB;
      end else if (do_write) begin
        w_held_r <= 1'b0;
      end
    end
  end

  // Only byte lane 0 carries register bits, so only strobe 0 matters.
  always_ff @(posedge MCLK) begin
    if (!RESET_N) begin
      port_direction_r <= FBP_DIR_RST;
      port_output_data_r <= FBP_DATA_RST;
      port_open_drain_r <= FBP_ODR_RST;
    end else if (do_write && w_strb_r[0]) begin
      unique case (aw_addr_r)
        FBP_ADDR_DIR: port_direction_r <= w_data_r[3:0];
        FBP_ADDR_DATA: port_output_data_r <= w_data_r[3:0];
        FBP_ADDR_ODR: port_open_drain_r <= w_data_r[3:0];
        default: port_direction_r <= port_direction_r;
      endcase
    end
  end

  always_ff @(posedge MCLK) begin
    if (!RESET_N) begin
      S_AXI_BVALID <= 1'b0;
      S_AXI_BRESP <= FBP_RESP_OKAY;
    end else if (do_write) begin
      S_AXI_BVALID <= 1'b1;
      S_AXI_BRESP <= (aw_addr_r == FBP_ADDR_PIN || aw_addr_r[1:0] != 2'h0) ?
                     FBP_RESP_SLVERR : FBP_RESP_OKAY;
    end else if (S_AXI_BREADY) begin
      S_AXI_BVALID <= 1'b0;
    end
  end

  // Input pins read back as the live level, output pins as the data bit.
  assign pin_state = (port_direction_r & port_output_data_r) |
                     (~port_direction_r & PIN_IN);

  always_comb begin
    rdata_nxt = 32'h0000_0000;
    rresp_nxt = FBP_RESP_OKAY;
    unique case (S_AXI_ARADDR)
      FBP_ADDR_DIR: rdata_nxt = FBP_UNDEF_READ;
      FBP_ADDR_DATA: rdata_nxt = {28'h0000000, port_output_data_r};
      FBP_ADDR_PIN: rdata_nxt = {FBP_UNDEF_READ[31:4], pin_state};
      FBP_ADDR_ODR: rdata_nxt = {28'h0000000, port_open_drain_r};
      default: rresp_nxt = FBP_RESP_SLVERR;
    endcase
  end

  always_ff @(posedge MCLK) begin
    if (!RESET_N) begin
      S_AXI_ARREADY <= 1'b0;
      S_AXI_RVALID <= 1'b0;
      S_AXI_RDATA <= 32'h0000_0000;
      S_AXI_RRESP <= FBP_RESP_OKAY;
    end else begin
      S_AXI_ARREADY <= ~S_AXI_ARREADY & ~S_AXI_RVALID & S_AXI_ARVALID;
      if (S_AXI_ARVALID & S_AXI_ARREADY) begin
        S_AXI_RVALID <= 1'b1;
        S_AXI_RDATA <= rdata_nxt;
        S_AXI_RRESP <= rresp_nxt;
      end else if (S_AXI_RREADY) begin
        S_AXI_RVALID <= 1'b0;
      end
    end
  end

  // ---------------------------------------------------------------
  // Pin function selection.
  // ---------------------------------------------------------------
  logic bus_ok;
  logic ack_on_p2;
  logic req_in_on_p1;
  logic req_out_on_p0;
  logic ch4_out;
  logic ch3a_out;
  logic ch3c_out;
  logic [3:0] en_c;
  logic [3:0] val_c;
  logic [3:0] od_c;
  logic p2_sck_in;
  logic p1_rx_in;

  // Single-chip modes with expansion off lose the bus release pins.
  assign bus_ok = ~(~EXTERNAL_EXPANSION & (OPERATING_MODE == FBP_MODE_3 ||
                  OPERATING_MODE == FBP_MODE_5 || OPERATING_MODE == FBP_MODE_7));
  assign ack_on_p2 = bus_ok & BUS_RELEASE_ENABLE & BUS_ACK_PIN_SELECT;
  assign req_in_on_p1 = bus_ok & BUS_RELEASE_ENABLE & BUS_REQUEST_PIN_SELECT;
  assign req_out_on_p0 = bus_ok & BUS_RELEASE_ENABLE & BUS_REQUEST_OUT_ENABLE &
                         BUS_REQUEST_OUT_PIN_SELECT;

  // Channel 4: compare, PWM1 or PWM2 unless clear is set to its own pin.
  assign ch4_out = PULSE_UNIT_PIN_SELECT & (
    (PULSE_CH4_MODE == FBP_MD_NORMAL && PULSE_CH4_IO_SELECT[3] == 1'b0 &&
     PULSE_CH4_IO_SELECT[1:0] != 2'h0) ||
    (PULSE_CH4_MODE == FBP_MD_PWM1 && PULSE_CH4_IO_SELECT[1:0] != 2'h0) ||
    (PULSE_CH4_MODE == FBP_MD_PWM2 && PULSE_CH4_IO_SELECT[1:0] != 2'h0 &&
     PULSE_CH4_CLEAR_SELECT != FBP_CCLR4_OWN));
  assign ch3a_out = PULSE_UNIT_PIN_SELECT & (
    (PULSE_CH3_MODE == FBP_MD_NORMAL && PULSE_CH3_IOA_SELECT[3] == 1'b0 &&
     PULSE_CH3_IOA_SELECT[1:0] != 2'h0) ||
    (PULSE_CH3_MODE == FBP_MD_PWM1 && PULSE_CH3_IOA_SELECT[1:0] != 2'h0) ||
    (PULSE_CH3_MODE == FBP_MD_PWM2 && PULSE_CH3_IOA_SELECT[1:0] != 2'h0 &&
     PULSE_CH3_CLEAR_SELECT != FBP_CCLR3_A));
  assign ch3c_out = PULSE_UNIT_PIN_SELECT & (
    (PULSE_CH3_MODE == FBP_MD_NORMAL && PULSE_CH3_IOC_SELECT[3] == 1'b0 &&
     PULSE_CH3_IOC_SELECT[1:0] != 2'h0) ||
    (PULSE_CH3_MODE == FBP_MD_PWM1 && PULSE_CH3_IOC_SELECT[1:0] != 2'h0) ||
    (PULSE_CH3_MODE == FBP_MD_PWM2 && PULSE_CH3_IOC_SELECT[1:0] != 2'h0 &&
     PULSE_CH3_CLEAR_SELECT != FBP_CCLR3_C));

  // Selection is purely combinational; the pad stage adds one register.
  always_comb begin
    en_c = port_direction_r;
    val_c = port_output_data_r;
    od_c = port_open_drain_r;
    p2_sck_in = 1'b0;
    p1_rx_in = 1'b0;
    // Pin 3: only port direction; nothing else may claim it.
    // Pin 2.
    if (ack_on_p2) begin
      en_c[2] = 1'b1;
      val_c[2] = BUS_ACK_OUT;
      od_c[2] = 1'b0;
    end else if (ch4_out) begin
      en_c[2] = 1'b1;
      val_c[2] = PULSE_CH4_OUT;
    end else if (BYTE_TIMER_PIN_SELECT && BYTE_TIMER_OUTPUT_SELECT != 4'h0) begin
      en_c[2] = 1'b1;
      val_c[2] = BYTE_TIMER_OUTPUT_ALT;
    end else if (SERIAL_CLOCK_SEL_HIGH) begin
      en_c[2] = 1'b0;
      p2_sck_in = 1'b1;
    end else if (SERIAL_SYNC_MODE || SERIAL_CLOCK_SEL_LOW) begin
      en_c[2] = 1'b1;
      val_c[2] = SERIAL_CLOCK_OUT;
    end else if (port_direction_r[2] && PATTERN_OUT_ENABLE_FOUR && PATTERN_PIN_SELECT) begin
      val_c[2] = PATTERN_OUT[2];
    end
    // Pin 1.
    if (req_in_on_p1) begin
      en_c[1] = 1'b0;
    end else if (IIC_BUS_ENABLE) begin
      en_c[1] = 1'b1;
      val_c[1] = IIC_CLOCK_OUT;
      od_c[1] = 1'b1;
    end else if (ch3c_out) begin
      en_c[1] = 1'b1;
      val_c[1] = PULSE_CH3C_OUT;
    end else if (RX_ENABLE) begin
      en_c[1] = 1'b0;
      p1_rx_in = 1'b1;
    end else if (port_direction_r[1] && PATTERN_OUT_ENABLE_TWO && PATTERN_PIN_SELECT) begin
      val_c[1] = PATTERN_OUT[1];
    end
    // Pin 0.
    if (req_out_on_p0) begin
      en_c[0] = 1'b1;
      val_c[0] = BUS_REQUEST_OUTPUT;
      od_c[0] = 1'b0;
    end else if (IIC_BUS_ENABLE) begin
      en_c[0] = 1'b1;
      val_c[0] = IIC_DATA_OUT;
      od_c[0] = 1'b1;
    end else if (ch3a_out) begin
      en_c[0] = 1'b1;
      val_c[0] = PULSE_CH3A_OUT;
    end else if (TRANSMIT_ENABLE) begin
      en_c[0] = 1'b1;
      val_c[0] = SERIAL_TRANSMIT_OUT;
    end else if (port_direction_r[0] && PATTERN_OUT_ENABLE_ZERO && PATTERN_PIN_SELECT) begin
      val_c[0] = PATTERN_OUT[0];
    end
  end

  fbp_pin_if sel_if [FBP_NPINS] ();
  genvar gi;
  generate
    for (gi = 0; gi < FBP_NPINS; gi++) begin : g_pin
      assign sel_if[gi].drive_en = en_c[gi];
      assign sel_if[gi].drive_val = val_c[gi];
      assign sel_if[gi].open_drain = od_c[gi];
      fbp_pad u_pad (
        .clk(MCLK),
        .rst_n(RESET_N),
        .sel(sel_if[gi]),
        .pin_out(PIN_OUT[gi]),
        .pin_oe(PIN_OE[gi])
      );
    end
  endgenerate

  // ---------------------------------------------------------------
  // Inputs forwarded to peripherals, registered for clean outputs.
  // ---------------------------------------------------------------
  always_ff @(posedge MCLK) begin
    if (!RESET_N) begin
      CONV_EXTERNAL_TRIGGER <= 1'b0;
      IRQ_ALT_A <= 4'h0;
      SERIAL_RECEIVE_IN <= 1'b0;
      SERIAL_CLOCK_IN <= 1'b0;
      BUS_REQUEST_INPUT <= 1'b0;
      IIC_CLOCK_IN <= 1'b0;
      IIC_DATA_IN <= 1'b0;
      PULSE_UNIT_IO_IN <= 4'h0;
    end else begin
      CONV_EXTERNAL_TRIGGER <= PIN_IN[3] & ~CONV_EXTENDED_TRIGGER_SEL &
                               CONV_TRIGGER_SEL_HIGH & CONV_TRIGGER_SEL_LOW;
      IRQ_ALT_A <= PIN_IN & ~IRQ_PIN_SELECT;
      SERIAL_RECEIVE_IN <= p1_rx_in & PIN_IN[1];
      SERIAL_CLOCK_IN <= p2_sck_in & PIN_IN[2];
      BUS_REQUEST_INPUT <= req_in_on_p1 & PIN_IN[1];
      IIC_CLOCK_IN <= IIC_BUS_ENABLE & PIN_IN[1];
      IIC_DATA_IN <= IIC_BUS_ENABLE & PIN_IN[0];
      PULSE_UNIT_IO_IN <= {1'b0, PIN_IN[2:0] & {3{PULSE_UNIT_PIN_SELECT}}};
    end
  end

  // ---------------------------------------------------------------
  // Assertions.
  // ---------------------------------------------------------------
  property p_read_dir_undef;
    @(posedge MCLK) disable iff (!RESET_N)
    (S_AXI_ARVALID && S_AXI_ARREADY && S_AXI_ARADDR == FBP_ADDR_DIR) |=>
    (S_AXI_RDATA == FBP_UNDEF_READ);
  endproperty
  a_read_dir_undef: assert property (p_read_dir_undef) else $error("dir read leaked");

  property p_port_out;
    @(posedge MCLK) disable iff (!RESET_N)
    (!ack_on_p2 && !ch4_out && !BYTE_TIMER_PIN_SELECT && !SERIAL_CLOCK_SEL_HIGH &&
     !SERIAL_SYNC_MODE && !SERIAL_CLOCK_SEL_LOW && !port_open_drain_r[2]) |=>
    (PIN_OE[2] == $past(port_direction_r[2]));
  endproperty
  a_port_out: assert property (p_port_out) else $error("pin 2 direction wrong");

  property p_data_read;
    @(posedge MCLK) disable iff (!RESET_N)
    (S_AXI_ARVALID && S_AXI_ARREADY && S_AXI_ARADDR == FBP_ADDR_DATA) |=>
    (S_AXI_RDATA[31:4] == 28'h0000000 && S_AXI_RDATA[3:0] == $past(port_output_data_r));
  endproperty
  a_data_read: assert property (p_data_read) else $error("data read wrong");

  property p_pin_read;
    @(posedge MCLK) disable iff (!RESET_N)
    (S_AXI_ARVALID && S_AXI_ARREADY && S_AXI_ARADDR == FBP_ADDR_PIN) |=>
    (S_AXI_RDATA[3:0] == $past((port_direction_r & port_output_data_r) |
     (~port_direction_r & PIN_IN)));
  endproperty
  a_pin_read: assert property (p_pin_read) else $error("pin state read wrong");

  property p_trigger;
    @(posedge MCLK) disable iff (!RESET_N)
    1'b1 |=> (CONV_EXTERNAL_TRIGGER == ($past(PIN_IN[3]) &&
     !$past(CONV_EXTENDED_TRIGGER_SEL) && $past(CONV_TRIGGER_SEL_HIGH) &&
     $past(CONV_TRIGGER_SEL_LOW)));
  endproperty
  a_trigger: assert property (p_trigger) else $error("trigger wrong");

  property p_irq;
    @(posedge MCLK) disable iff (!RESET_N)
    (IRQ_PIN_SELECT[0] == 1'b0 && PIN_IN[0]) |=> IRQ_ALT_A[0];
  endproperty
  a_irq: assert property (p_irq) else $error("irq 0 not fed");

  property p_ack;
    @(posedge MCLK) disable iff (!RESET_N)
    ack_on_p2 |=> (PIN_OE[2] && PIN_OUT[2] == $past(BUS_ACK_OUT));
  endproperty
  a_ack: assert property (p_ack) else $error("ack not driven");

  property p_iic_od;
    @(posedge MCLK) disable iff (!RESET_N)
    (IIC_BUS_ENABLE && !req_out_on_p0 && IIC_DATA_OUT) |=> !PIN_OE[0];
  endproperty
  a_iic_od: assert property (p_iic_od) else $error("iic data drove high");

  property p_req_out;
    @(posedge MCLK) disable iff (!RESET_N)
    req_out_on_p0 |=> (PIN_OE[0] && PIN_OUT[0] == $past(BUS_REQUEST_OUTPUT));
  endproperty
  a_req_out: assert property (p_req_out) else $error("request out wrong");

  property p_single_chip;
    @(posedge MCLK) disable iff (!RESET_N)
    (!EXTERNAL_EXPANSION && (OPERATING_MODE == FBP_MODE_3 || OPERATING_MODE == FBP_MODE_5 ||
     OPERATING_MODE == FBP_MODE_7)) |-> !ack_on_p2 && !req_in_on_p1 && !req_out_on_p0;
  endproperty
  a_single_chip: assert property (p_single_chip) else $error("bus pin in chip mode");

  c_write: cover property (@(posedge MCLK) disable iff (!RESET_N) do_write);
  c_ack: cover property (@(posedge MCLK) disable iff (!RESET_N) ack_on_p2);
  c_iic: cover property (@(posedge MCLK) disable iff (!RESET_N) IIC_BUS_ENABLE && PIN_OE[1]);
endmodule // fbp_port

// >>> tb/fbp_board.sv
// Board model that resolves each port pin from the port drive, an external driver and a pull-up.
`timescale 1ns/1ps
module fbp_board (
  input wire logic [3:0] pin_out,
  input wire logic [3:0] pin_oe,
  input wire logic [3:0] ext_en,
  input wire logic [3:0] ext_val,
  output logic [3:0] pin_lvl
);
  // -------------------------------------------------------------
  // Pin resolution
  // -------------------------------------------------------------
  // A released pin with no external driver floats up to the pull-up, so open-drain high reads 1.
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      pin_lvl[i] = pin_oe[i] ? pin_out[i] : (ext_en[i] ? ext_val[i] : 1'b1);
    end
  end
endmodule // fbp_board

// >>> tb/fbp_port_bench.sv
// Self-checking bench for the four-bit multiplexed I/O port.
`timescale 1ns/1ps
module fbp_port_bench;
  import fbp_pkg::*;
  logic MCLK, RESET_N, S_AXI_AWVALID, S_AXI_WVALID, S_AXI_BREADY, S_AXI_ARVALID, S_AXI_RREADY;
  logic S_AXI_AWREADY, S_AXI_WREADY, S_AXI_BVALID, S_AXI_ARREADY, S_AXI_RVALID;
  logic [3:0] S_AXI_AWADDR, S_AXI_WSTRB, S_AXI_ARADDR, PIN_IN, PIN_OUT, PIN_OE, IRQ_ALT_A;
  logic [31:0] S_AXI_WDATA, S_AXI_RDATA;
  logic [1:0] S_AXI_BRESP, S_AXI_RRESP, PULSE_CH4_CLEAR_SELECT;
  logic [2:0] OPERATING_MODE, PATTERN_OUT, PULSE_CH3_CLEAR_SELECT;
  logic [3:0] BYTE_TIMER_OUTPUT_SELECT, PULSE_CH4_MODE, PULSE_CH4_IO_SELECT, PULSE_CH3_MODE;
  logic [3:0] PULSE_CH3_IOA_SELECT, PULSE_CH3_IOC_SELECT, IRQ_PIN_SELECT, PULSE_UNIT_IO_IN;
  logic EXTERNAL_EXPANSION, BUS_RELEASE_ENABLE, BUS_ACK_PIN_SELECT, BUS_REQUEST_PIN_SELECT;
  logic BUS_REQUEST_OUT_ENABLE, BUS_REQUEST_OUT_PIN_SELECT, BUS_ACK_OUT, BUS_REQUEST_OUTPUT;
  logic IIC_BUS_ENABLE, IIC_CLOCK_OUT, IIC_DATA_OUT, RX_ENABLE, TRANSMIT_ENABLE;
  logic SERIAL_TRANSMIT_OUT, SERIAL_CLOCK_OUT, SERIAL_SYNC_MODE, SERIAL_CLOCK_SEL_LOW;
  logic SERIAL_CLOCK_SEL_HIGH, PATTERN_OUT_ENABLE_FOUR, PATTERN_OUT_ENABLE_TWO;
  logic PATTERN_OUT_ENABLE_ZERO, PATTERN_PIN_SELECT, PULSE_UNIT_PIN_SELECT, BYTE_TIMER_PIN_SELECT;
  logic BYTE_TIMER_OUTPUT_ALT, PULSE_CH4_OUT, PULSE_CH3A_OUT, PULSE_CH3C_OUT;
  logic CONV_TRIGGER_SEL_HIGH, CONV_TRIGGER_SEL_LOW, CONV_EXTENDED_TRIGGER_SEL;
  logic CONV_EXTERNAL_TRIGGER, SERIAL_RECEIVE_IN, SERIAL_CLOCK_IN, BUS_REQUEST_INPUT;
  logic IIC_CLOCK_IN, IIC_DATA_IN;
  logic [3:0] ext_en, ext_val;
  logic [1:0] resp;
  logic [31:0] rd;
  int n_mismatch, cmp_count, cyc;

  fbp_port dut (.*);
  fbp_board board (.pin_out(PIN_OUT), .pin_oe(PIN_OE), .ext_en(ext_en), .ext_val(ext_val),
    .pin_lvl(PIN_IN));

  // -------------------------------------------------------------
  // Shared tasks
  // -------------------------------------------------------------
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // Address and data are offered together; each is released once taken.
  task automatic axw(input logic [3:0] a, input logic [31:0] d);
    logic aw_ok, w_ok;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    @(posedge MCLK);
    S_AXI_AWADDR <= a;
    S_AXI_WDATA <= d;
    S_AXI_WSTRB <= 4'hF;
    S_AXI_AWVALID <= 1'b1;
    S_AXI_WVALID <= 1'b1;
    S_AXI_BREADY <= 1'b1;
    while (!(aw_ok && w_ok)) begin
      @(posedge MCLK);
      if (S_AXI_AWREADY === 1'b1) begin
        aw_ok = 1'b1;
        S_AXI_AWVALID <= 1'b0;
      end
      if (S_AXI_WREADY === 1'b1) begin
        w_ok = 1'b1;
        S_AXI_WVALID <= 1'b0;
      end
    end
    do @(posedge MCLK); while (S_AXI_BVALID !== 1'b1);
    resp = S_AXI_BRESP;
    S_AXI_BREADY <= 1'b0;
  endtask

  task automatic axr(input logic [3:0] a);
    @(posedge MCLK);
    S_AXI_ARADDR <= a;
    S_AXI_ARVALID <= 1'b1;
    S_AXI_RREADY <= 1'b1;
    do @(posedge MCLK); while (S_AXI_ARREADY !== 1'b1);
    S_AXI_ARVALID <= 1'b0;
    do @(posedge MCLK); while (S_AXI_RVALID !== 1'b1);
    rd = S_AXI_RDATA;
    resp = S_AXI_RRESP;
    S_AXI_RREADY <= 1'b0;
  endtask

  // Pins and forwarded inputs pass a register stage or two before they settle.
  task automatic st();
    repeat (3) @(posedge MCLK);
  endtask

  // -------------------------------------------------------------
  // Scenarios
  // -------------------------------------------------------------
  task automatic t_reset();
    axr(FBP_ADDR_DATA);
    chk("data rst", 32'h0, rd);
    axr(FBP_ADDR_ODR);
    chk("odr rst", 32'h0, rd);
    axw(FBP_ADDR_DIR, 32'h0000_000F);
    axr(FBP_ADDR_DIR);
    chk("dir read", FBP_UNDEF_READ, rd);
    $display("test reset done");
  endtask

  task automatic t_output();
    axw(FBP_ADDR_DATA, 32'hFFFF_FFFA);
    axr(FBP_ADDR_DATA);
    chk("data upper", 32'h0000_000A, rd);
    axr(FBP_ADDR_PIN);
    chk("pin out", 32'h0000_000A, rd[31:0] & 32'hF);
    st();
    chk("oe", 32'hF, 32'(PIN_OE));
    chk("out", 32'hA, 32'(PIN_OUT));
    $display("test output done");
  endtask

  task automatic t_input();
    axw(FBP_ADDR_DIR, 32'h0);
    ext_en <= 4'hF;
    ext_val <= 4'h5;
    st();
    chk("oe in", 32'h0, 32'(PIN_OE));
    axr(FBP_ADDR_PIN);
    chk("pin in", 32'h5, rd & 32'hF);
    chk("irq", 32'h5, 32'(IRQ_ALT_A));
    axw(FBP_ADDR_PIN, 32'hF);
    chk("ro resp", 32'(FBP_RESP_SLVERR), 32'(resp));
    axw(4'h2, 32'hF);
    chk("bad addr", 32'(FBP_RESP_SLVERR), 32'(resp));
    axr(4'h2);
    chk("bad rd resp", 32'(FBP_RESP_SLVERR), 32'(resp));
    chk("bad rd data", 32'h0, rd);
    CONV_TRIGGER_SEL_HIGH <= 1'b1;
    CONV_TRIGGER_SEL_LOW <= 1'b1;
    ext_val <= 4'h8;
    st();
    chk("trig on", 32'h1, 32'(CONV_EXTERNAL_TRIGGER));
    CONV_EXTENDED_TRIGGER_SEL <= 1'b1;
    st();
    chk("trig off", 32'h0, 32'(CONV_EXTERNAL_TRIGGER));
    ext_en <= 4'h0;
    $display("test input done");
  endtask

  task automatic t_drain();
    axw(FBP_ADDR_DIR, 32'hF);
    axw(FBP_ADDR_ODR, 32'h5);
    axw(FBP_ADDR_DATA, 32'h0);
    st();
    chk("od low", 32'hF, 32'(PIN_OE));
    axw(FBP_ADDR_DATA, 32'h5);
    st();
    chk("od high", 32'hA, 32'(PIN_OE));
    IIC_BUS_ENABLE <= 1'b1;
    IIC_CLOCK_OUT <= 1'b1;
    IIC_DATA_OUT <= 1'b0;
    st();
    chk("iic oe", 32'h9, 32'(PIN_OE));
    chk("iic clk in", 32'h1, 32'(IIC_CLOCK_IN));
    chk("iic data in", 32'h0, 32'(IIC_DATA_IN));
    IIC_DATA_OUT <= 1'b1;
    st();
    chk("iic release", 32'h8, 32'(PIN_OE));
    IIC_BUS_ENABLE <= 1'b0;
    $display("test open drain done");
  endtask

  task automatic t_busack();
    axw(FBP_ADDR_DATA, 32'h0);
    OPERATING_MODE <= 3'h1;
    BUS_RELEASE_ENABLE <= 1'b1;
    BUS_ACK_PIN_SELECT <= 1'b1;
    BUS_ACK_OUT <= 1'b1;
    st();
    chk("ack oe", 32'h1, 32'(PIN_OE[2]));
    chk("ack out", 32'h1, 32'(PIN_OUT[2]));
    OPERATING_MODE <= FBP_MODE_3;
    st();
    chk("single oe", 32'h1, 32'(PIN_OE[2]));
    chk("single out", 32'h0, 32'(PIN_OUT[2]));
    PULSE_UNIT_PIN_SELECT <= 1'b1;
    PULSE_CH4_IO_SELECT <= 4'h5;
    PULSE_CH4_OUT <= 1'b1;
    st();
    chk("pulse out", 32'h1, 32'(PIN_OUT[2]));
    chk("pulse in", 32'h4, 32'(PULSE_UNIT_IO_IN));
    $display("test bus ack done");
  endtask

  // -------------------------------------------------------------
  // Clock, reset, watchdog and verdict
  // -------------------------------------------------------------
  initial begin
    MCLK = 1'b0;
    forever #5 MCLK = ~MCLK;
  end

  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  always @(posedge MCLK) begin
    cyc++;
    if (cyc == 5000) begin
      n_mismatch++;
      stop_test();
    end
  end

  initial begin
    {S_AXI_AWVALID, S_AXI_WVALID, S_AXI_BREADY, S_AXI_ARVALID, S_AXI_RREADY, S_AXI_AWADDR,
     S_AXI_WSTRB, S_AXI_ARADDR, S_AXI_WDATA, OPERATING_MODE, PATTERN_OUT, PULSE_CH3_CLEAR_SELECT,
     PULSE_CH4_CLEAR_SELECT, BYTE_TIMER_OUTPUT_SELECT, PULSE_CH4_MODE, PULSE_CH4_IO_SELECT,
     PULSE_CH3_MODE, PULSE_CH3_IOA_SELECT, PULSE_CH3_IOC_SELECT, IRQ_PIN_SELECT,
     EXTERNAL_EXPANSION, BUS_RELEASE_ENABLE, BUS_ACK_PIN_SELECT, BUS_REQUEST_PIN_SELECT,
     BUS_REQUEST_OUT_ENABLE, BUS_REQUEST_OUT_PIN_SELECT, BUS_ACK_OUT, BUS_REQUEST_OUTPUT,
     IIC_BUS_ENABLE, IIC_CLOCK_OUT, IIC_DATA_OUT, RX_ENABLE, TRANSMIT_ENABLE,
     SERIAL_TRANSMIT_OUT, SERIAL_CLOCK_OUT, SERIAL_SYNC_MODE, SERIAL_CLOCK_SEL_LOW,
     SERIAL_CLOCK_SEL_HIGH, PATTERN_OUT_ENABLE_FOUR, PATTERN_OUT_ENABLE_TWO,
     PATTERN_OUT_ENABLE_ZERO, PATTERN_PIN_SELECT, PULSE_UNIT_PIN_SELECT, BYTE_TIMER_PIN_SELECT,
     BYTE_TIMER_OUTPUT_ALT, PULSE_CH4_OUT, PULSE_CH3A_OUT, PULSE_CH3C_OUT,
     CONV_TRIGGER_SEL_HIGH, CONV_TRIGGER_SEL_LOW, CONV_EXTENDED_TRIGGER_SEL,
     RESET_N, ext_en, ext_val} <= '0;
    repeat (20) @(posedge MCLK);
    RESET_N <= 1'b1;
    @(posedge MCLK);
    t_reset();
    t_output();
    t_input();
    t_drain();
    t_busack();
    stop_test();
  end
endmodule // fbp_port_bench
